// ---- rtl/spl_regs.vh ----
// constants for the sampler pacing and interlock block
// assumes a 100 MHz clock and an apb slave with 32-bit word registers
// Behaviour
// - a flow pulse counts only if held high at least 25 ms
// - changing bottle count or size regenerates sequence and flags reprogramming
// - the level inhibit is obeyed only when inhibit enable is set
// - latch mode keeps sampling after the level signal falls away
// - toggle mode halts sampling whenever the level leaves the sensor
// - master/slave works only with the mode enabled on both units
// - a running master drives the inhibit out on the shared line
// - a slave stays dormant while inhibited, then starts its own routine
// - when the master finishes, roles swap and the former slave drives inhibit
// - in master/slave mode the inhibit replaces the bottle-number output
// - the master/slave inhibit is a steady level, never a bottle code
// - start puts a unit in run; the first one running becomes master
// - roles swap only if both run; otherwise the cycle stops
`ifndef SPL_REGS_VH
`define SPL_REGS_VH

// register byte offsets
`define SPL_CTRL_OFF 12'h000
`define SPL_CFG_OFF 12'h004
`define SPL_CMD_OFF 12'h008
`define SPL_STAT_OFF 12'h00c
`define SPL_FLOW_OFF 12'h010
`define SPL_ISTAT_OFF 12'h014
`define SPL_IMASK_OFF 12'h018

// control fields
`define SPL_CTRL_INH_EN 0
`define SPL_CTRL_LATCH 1
`define SPL_CTRL_MS_EN 2
`define SPL_CTRL_BOTTLE 3
`define SPL_CTRL_W 4
`define SPL_CTRL_RST 4'h0

// config: bottle count [7:0], bottle size [23:8]
`define SPL_CFG_W 24
`define SPL_CFG_RST 24'h000000

// command bits, write one to act
`define SPL_CMD_START 0
`define SPL_CMD_DONE 1
`define SPL_CMD_STOP 2
`define SPL_CMD_PROG 3

// interrupt status bits
`define SPL_IRQ_FLOW 0
`define SPL_IRQ_REPROG 1
`define SPL_IRQ_SWAP 2
`define SPL_IRQ_DONE 3
`define SPL_IRQ_W 4
`define SPL_IRQ_RST 4'h0

// timing
// 25 ms at 100 MHz, sized to the width counter so no bits are dropped
`define SPL_FLOW_MIN_CYC 22'h2625a0
`define SPL_INH_MIN_CYC 22'h000002
`define SPL_CNT_W 22
`define SPL_FLOW_CNT_W 16

`endif

// ---- rtl/spl_qualify.v ----
// input qualifier: two-flop synchroniser then a width counter
// assumes the input is a slow level; min_cyc is at least 2
`timescale 1ns/1ps
`default_nettype none
`include "spl_regs.vh"
module spl_qualify #(
  parameter [`SPL_CNT_W-1:0] MIN_CYC = `SPL_INH_MIN_CYC
) (
  input wire clk, // system clock
  input wire reset_n, // synchronous reset, active low
  input wire raw_in, // asynchronous pin level
  output reg qual_level, // high once the input held for min_cyc
  output reg qual_pulse // one cycle when a pulse qualifies
);
  reg sync1_reg;
  reg sync2_reg;
  reg [`SPL_CNT_W-1:0] width_reg;

  // synchroniser; the first flop feeds only the second
  always @(posedge clk) begin
    if (!reset_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  // width counter; short pulses are dropped when the level falls
  always @(posedge clk) begin
    if (!reset_n) begin
      width_reg <= {`SPL_CNT_W{1'b0}};
      qual_level <= 1'b0;
      qual_pulse <= 1'b0;
    end else begin
      qual_pulse <= 1'b0;
      if (!sync2_reg) begin
        width_reg <= {`SPL_CNT_W{1'b0}};
        qual_level <= 1'b0;
      end else if (width_reg != MIN_CYC) begin
        width_reg <= width_reg + 1'b1;
        if (width_reg == MIN_CYC - 1'b1) begin
          qual_level <= 1'b1;
          qual_pulse <= 1'b1; // one count per pulse, saturated after
        end
      end
    end
  end
endmodule // spl_qualify
`default_nettype wire

// ---- rtl/spl_pacing.v ----
// sampler pacing and interlock: flow pulses, level inhibit, master/slave
// assumes apb master on clk; pin levels are plain inputs from the connector
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "spl_regs.vh"
module spl_pacing #(
  parameter [`SPL_CNT_W-1:0] FLOW_MIN_CYC = `SPL_FLOW_MIN_CYC
) (
  input wire clk, // system clock, 100 MHz
  input wire reset_n, // synchronous reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb write
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire pready, // apb ready, always high
  output reg [31:0] prdata, // apb read data
  output reg pslverr, // apb error on unmapped address
  input wire flow_pulse_in, // flow pulse pin
  input wire inhibit_in, // inhibit pin, high inhibits
  output reg bottle_ms_out, // shared bottle number / master-slave line
  output reg routine_active, // sampling routine running
  output reg is_master, // unit holds the master role
  output reg flow_tick, // one cycle per qualified pulse while running
  output reg seq_regen, // one cycle request to rebuild program sequence
  output wire irq // level interrupt
);
  // states, one-hot
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_SLAVE = 3'b010;
  localparam [2:0] S_ACTIVE = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [`SPL_CTRL_W-1:0] ctrl_reg;
  reg [`SPL_CFG_W-1:0] cfg_reg;
  reg [`SPL_IRQ_W-1:0] istat_reg;
  reg [`SPL_IRQ_W-1:0] imask_reg;
  reg [`SPL_FLOW_CNT_W-1:0] flow_cnt_reg;
  reg reprog_reg;
  reg latch_reg;
  reg swap_evt;
  reg done_evt;
  wire flow_level;
  wire flow_pulse;
  wire inh_level;
  wire wr_en;
  wire rd_en;
  wire cmd_wr;
  wire start_cmd;
  wire done_cmd;
  wire stop_cmd;
  wire ms_en;
  wire inh_en;
  wire level_ok;
  wire running;
  wire [`SPL_IRQ_W-1:0] irq_set;

  // flow pulse qualifier, 25 ms minimum width
  spl_qualify #(
    .MIN_CYC(FLOW_MIN_CYC)
  ) u_flow (
    .clk(clk),
    .reset_n(reset_n),
    .raw_in(flow_pulse_in),
    .qual_level(flow_level),
    .qual_pulse(flow_pulse)
  );

  // inhibit qualifier, short filter only
  spl_qualify #(
    .MIN_CYC(`SPL_INH_MIN_CYC)
  ) u_inh (
    .clk(clk),
    .reset_n(reset_n),
    .raw_in(inhibit_in),
    .qual_level(inh_level),
    .qual_pulse()
  );

  // apb decode; zero wait states so the access phase ends at once
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign cmd_wr = wr_en & (paddr == `SPL_CMD_OFF);
  assign start_cmd = cmd_wr & pwdata[`SPL_CMD_START];
  assign done_cmd = cmd_wr & pwdata[`SPL_CMD_DONE];
  assign stop_cmd = cmd_wr & pwdata[`SPL_CMD_STOP];

  // configuration views
  assign ms_en = ctrl_reg[`SPL_CTRL_MS_EN];
  assign inh_en = ctrl_reg[`SPL_CTRL_INH_EN] & ~ms_en;

  // level gating: ignored unless enabled, latch keeps going once released
  // pin high means the level is below the probe
  assign level_ok = ~inh_en | ~inh_level | (ctrl_reg[`SPL_CTRL_LATCH] & latch_reg);
  assign running = state_reg[2] & level_ok;

  // control and config registers
  always @(posedge clk) begin
    if (!reset_n) begin
      ctrl_reg <= `SPL_CTRL_RST;
      cfg_reg <= `SPL_CFG_RST;
      imask_reg <= `SPL_IRQ_RST;
    end else if (wr_en) begin
      if (paddr == `SPL_CTRL_OFF) begin
        ctrl_reg <= pwdata[`SPL_CTRL_W-1:0];
      end
      if (paddr == `SPL_CFG_OFF) begin
        cfg_reg <= pwdata[`SPL_CFG_W-1:0];
      end
      if (paddr == `SPL_IMASK_OFF) begin
        imask_reg <= pwdata[`SPL_IRQ_W-1:0];
      end
    end
  end

  // changed bottle settings invalidate the stored program
  always @(posedge clk) begin
    if (!reset_n) begin
      reprog_reg <= 1'b0;
      seq_regen <= 1'b0;
    end else begin
      seq_regen <= 1'b0;
      if (wr_en && paddr == `SPL_CFG_OFF && pwdata[`SPL_CFG_W-1:0] != cfg_reg) begin
        reprog_reg <= 1'b1;
        seq_regen <= 1'b1;
      end else if (cmd_wr && pwdata[`SPL_CMD_PROG]) begin
        reprog_reg <= 1'b0; // new program loaded
      end
    end
  end

  // latch holds once the level has allowed sampling in this run
  always @(posedge clk) begin
    if (!reset_n) begin
      latch_reg <= 1'b0;
    end else if (!state_reg[2]) begin
      latch_reg <= 1'b0;
    end else if (!inh_level) begin
      latch_reg <= 1'b1;
    end
  end

  // role sequencer
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        // first unit running takes master; a busy peer makes us slave
        if (start_cmd) begin
          if (ms_en && inh_level) begin
            state_next = S_SLAVE;
          end else begin
            state_next = S_ACTIVE;
          end
        end
      end
      S_SLAVE: begin
        if (stop_cmd || !ms_en) begin
          state_next = S_IDLE;
        end else if (!inh_level) begin
          state_next = S_ACTIVE;
        end
      end
      S_ACTIVE: begin
        // finishing leaves run; peer only swaps in if it is still running
        if (done_cmd || stop_cmd) begin
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // state register and swap/done events
  always @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= S_IDLE;
      swap_evt <= 1'b0;
      done_evt <= 1'b0;
    end else begin
      state_reg <= state_next;
      swap_evt <= state_reg[1] & state_next[2];
      done_evt <= state_reg[2] & state_next[0] & done_cmd;
    end
  end

  // pin outputs; inhibit is a steady level, no bottle code on the line
  always @(posedge clk) begin
    if (!reset_n) begin
      bottle_ms_out <= 1'b0;
      routine_active <= 1'b0;
      is_master <= 1'b0;
      flow_tick <= 1'b0;
    end else begin
      if (ms_en) begin
        bottle_ms_out <= state_reg[2];
      end else begin
        bottle_ms_out <= ctrl_reg[`SPL_CTRL_BOTTLE];
      end
      routine_active <= running;
      is_master <= ms_en & state_reg[2];
      flow_tick <= flow_pulse & running;
    end
  end

  // qualified pulse counter, cleared by a write to it
  always @(posedge clk) begin
    if (!reset_n) begin
      flow_cnt_reg <= {`SPL_FLOW_CNT_W{1'b0}};
    end else if (wr_en && paddr == `SPL_FLOW_OFF) begin
      flow_cnt_reg <= {`SPL_FLOW_CNT_W{1'b0}};
    end else if (flow_pulse && running) begin
      flow_cnt_reg <= flow_cnt_reg + 1'b1;
    end
  end

  // sticky events
  assign irq_set = {done_evt, swap_evt, seq_regen, flow_tick};

  // write one clears; a new event in the same cycle wins
  always @(posedge clk) begin
    if (!reset_n) begin
      istat_reg <= `SPL_IRQ_RST;
    end else if (wr_en && paddr == `SPL_ISTAT_OFF) begin
      istat_reg <= (istat_reg & ~pwdata[`SPL_IRQ_W-1:0]) | irq_set;
    end else begin
      istat_reg <= istat_reg | irq_set;
    end
  end

  assign irq = |(istat_reg & imask_reg);

  // read mux; unmapped addresses read zero and flag an error
  always @* begin
    prdata = 32'h00000000;
    pslverr = 1'b0;
    if (psel && penable) begin
      case (paddr)
        `SPL_CTRL_OFF: prdata[`SPL_CTRL_W-1:0] = ctrl_reg;
        `SPL_CFG_OFF: prdata[`SPL_CFG_W-1:0] = cfg_reg;
        `SPL_CMD_OFF: prdata = 32'h00000000;
        `SPL_STAT_OFF: prdata[7:0] = {flow_level, inh_level, reprog_reg, is_master, routine_active, state_reg};
        `SPL_FLOW_OFF: prdata[`SPL_FLOW_CNT_W-1:0] = flow_cnt_reg;
        `SPL_ISTAT_OFF: prdata[`SPL_IRQ_W-1:0] = istat_reg;
        `SPL_IMASK_OFF: prdata[`SPL_IRQ_W-1:0] = imask_reg;
        default: pslverr = 1'b1;
      endcase
    end
    if (!rd_en) begin
      prdata = 32'h00000000;
    end
  end
endmodule // spl_pacing
`default_nettype wire

// ---- verif/spl_pacing_assertions.sv ----
// port assertions for spl_pacing
// bound to every spl_pacing instance; one clock domain
`timescale 1ns/1ps
`default_nettype none
module spl_pacing_assertions #(
  parameter [21:0] FLOW_MIN_CYC = 22'h000014
) (
  input wire logic clk, // clock
  input wire logic reset_n, // sync reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [11:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic pready, // apb
  input wire logic [31:0] prdata, // apb
  input wire logic pslverr, // apb
  input wire logic flow_pulse_in, // pin
  input wire logic inhibit_in, // pin
  input wire logic bottle_ms_out, // pin
  input wire logic routine_active, // status
  input wire logic is_master, // status
  input wire logic flow_tick, // pulse
  input wire logic seq_regen, // pulse
  input wire logic irq // interrupt
);
  int run_len; // raw high run, held after the fall so a late tick still sees it
  logic pin_prev;
  wire cfg_wr = psel && penable && pwrite && (paddr == 12'h004);
  wire qual_raw = run_len >= int'(FLOW_MIN_CYC);
  // measure the latest raw high run on the flow pin
  always @(posedge clk) begin
    pin_prev <= reset_n && flow_pulse_in;
    if (!reset_n) begin
      run_len <= 0;
    end else if (flow_pulse_in) begin
      run_len <= pin_prev ? run_len + 1 : 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_tick_width: assert property (flow_tick |-> qual_raw) else $error("tick from short pulse");
  chk_tick_due: assert property ($rose(qual_raw) && routine_active |-> ##[1:8] flow_tick)
    else $error("qualified pulse gave no tick");
  chk_tick_single: assert property (flow_tick |=> !flow_tick) else $error("tick longer than one cycle");
  chk_master_line: assert property (is_master |-> bottle_ms_out && routine_active)
    else $error("master without inhibit out");
  chk_reset_clear: assert property ($rose(reset_n) |-> !(routine_active || is_master || bottle_ms_out || irq))
    else $error("outputs not cleared by reset");
  chk_regen_pulse: assert property (seq_regen |-> !$past(seq_regen) && ($past(cfg_wr) || $past(cfg_wr, 2)))
    else $error("regen without config write");
  chk_apb_idle: assert property (!(psel && penable) |-> prdata == 32'h00000000 && !pslverr)
    else $error("read data outside access");
  chk_unmapped_err: assert property (psel && penable && paddr > 12'h018 |-> pslverr) else $error("no error on hole");
  cov_tick: cover property (flow_tick);
  cov_master: cover property ($rose(is_master));
  cov_regen: cover property (seq_regen);
endmodule // spl_pacing_assertions
bind spl_pacing spl_pacing_assertions #(.FLOW_MIN_CYC(FLOW_MIN_CYC)) spl_pacing_assertions_inst (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .flow_pulse_in(flow_pulse_in),
  .inhibit_in(inhibit_in), .bottle_ms_out(bottle_ms_out), .routine_active(routine_active),
  .is_master(is_master), .flow_tick(flow_tick), .seq_regen(seq_regen), .irq(irq));
`default_nettype wire

// ---- verif/spl_peer_model.sv ----
// far side of the connector: flow meter closures and the inhibit level
// driven by bench task calls; pins change only just after rising edges
`timescale 1ns/1ps
`default_nettype none
module spl_peer_model (
  input wire logic clk, // clock
  output var logic flow_pulse_in, // closure, high while closed
  output var logic inhibit_in // high: level below probe or peer running
);
  initial begin
    flow_pulse_in = 1'b0;
    inhibit_in = 1'b0;
  end
  // one closure per equal flow increment; caller sets width
  task pulse(input int w);
    @(posedge clk);
    flow_pulse_in <= 1'b1;
    repeat (w) @(posedge clk);
    flow_pulse_in <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  // inhibit level: probe dry or peer master running, enabled peer
  task level(input logic v);
    @(posedge clk);
    inhibit_in <= v;
  endtask
endmodule // spl_peer_model
`default_nettype wire

// ---- verif/spl_pacing_tb.sv ----
// self-checking bench for spl_pacing: registers, flow, inhibit, master/slave
// assumes spl_peer_model drives the pins and the checker is bound
`timescale 1ns/1ps
`default_nettype none
module spl_pacing_tb;
  localparam int MIN = 20; // shortened qualifying width
  logic clk = 1'b0, reset_n = 1'b0, psel, penable, pwrite, rd_e;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd_q;
  wire pready, pslverr, flow_pulse_in, inhibit_in, bottle_ms_out, routine_active, is_master, flow_tick, seq_regen, irq;
  wire [31:0] prdata;
  int errors = 0, n_tests = 0, tick_n = 0, regen_n = 0;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} spl_row_t;
  // write d, read back q; e is the expected error flag
  spl_row_t rows [8] = '{'{12'h000, 32'hffffffff, 32'h0000000f, 1'b0}, '{12'h004, 32'hffffffff, 32'h00ffffff, 1'b0},
    '{12'h018, 32'hfffffff0, 32'h00000000, 1'b0}, '{12'h008, 32'h00000000, 32'h00000000, 1'b0},
    '{12'h00c, 32'hffffffff, 32'h00000021, 1'b0}, '{12'h010, 32'h00000000, 32'h00000000, 1'b0},
    '{12'h01c, 32'hffffffff, 32'h00000000, 1'b1}, '{12'h014, 32'h00000000, 32'h00000002, 1'b0}};
  always #5 clk = ~clk;
  // pulses counted here, checked after each burst
  always @(posedge clk) begin
    if (flow_tick === 1'b1) tick_n <= tick_n + 1;
    if (seq_regen === 1'b1) regen_n <= regen_n + 1;
  end
  spl_pacing #(.FLOW_MIN_CYC(22'h000014)) spl_pacing_inst (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .flow_pulse_in(flow_pulse_in), .inhibit_in(inhibit_in), .bottle_ms_out(bottle_ms_out),
    .routine_active(routine_active), .is_master(is_master), .flow_tick(flow_tick), .seq_regen(seq_regen), .irq(irq));
  spl_peer_model spl_peer_model_inst (.clk(clk), .flow_pulse_in(flow_pulse_in), .inhibit_in(inhibit_in));
  task report_and_stop;
    $display("comparisons %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task hang;
    errors++;
    report_and_stop;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) hang;
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // registers update in the edge's nba region; look at outputs once settled
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(negedge clk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] q);
    apb(1'b0, a, 32'h00000000);
    chk(rd_q, q);
  endtask
  // sel 0 routine_active, 1 is_master, 2 shared line; bounded
  task wait_until(input int sel, input logic v);
    int i;
    for (i = 0; i < 64; i++) begin
      @(negedge clk);
      if ((sel == 0 ? routine_active : sel == 1 ? is_master : bottle_ms_out) === v) break;
    end
    if (i == 64) hang;
  endtask
  task rst(input int n);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (n) @(posedge clk);
    reset_n <= 1'b1;
  endtask
  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h00000000;
    rst(5);
    rd(12'h00c, 32'h00000001);
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d);
      chk(rd_e, rows[k].e);
      rd(rows[k].a, rows[k].q);
    end
    // interrupt: masked, unmasked, then cleared by writing one
    chk(irq, 1'b0);
    wr(12'h018, 32'h00000002);
    chk(irq, 1'b1);
    wr(12'h014, 32'h00000002);
    chk(irq, 1'b0);
    // same config again is no change; program load clears the flag
    wr(12'h004, 32'h00ffffff);
    wr(12'h008, 32'h00000008);
    rd(12'h00c, 32'h00000001);
    chk(regen_n, 1);
    // reset in mid-run
    wr(12'h000, 32'h00000000);
    wr(12'h008, 32'h00000001);
    wait_until(0, 1'b1);
    rst(2);
    rd(12'h000, 32'h00000000);
    chk(routine_active, 1'b0);
    // flow: short, boundary and long pulse, inhibit ignored while disabled
    spl_peer_model_inst.level(1'b1);
    wr(12'h008, 32'h00000001);
    wait_until(0, 1'b1);
    spl_peer_model_inst.pulse(MIN - 2);
    spl_peer_model_inst.pulse(MIN);
    spl_peer_model_inst.pulse(MIN + 6);
    chk(tick_n, 2);
    chk(routine_active, 1'b1);
    rd(12'h010, 32'h00000002);
    wr(12'h010, 32'h00000000);
    rd(12'h010, 32'h00000000);
    wr(12'h008, 32'h00000004);
    wait_until(0, 1'b0);
    spl_peer_model_inst.pulse(MIN + 6);
    chk(tick_n, 2);
    // toggle mode halts while dry, resumes when wet
    spl_peer_model_inst.level(1'b0);
    wr(12'h000, 32'h00000001);
    wr(12'h008, 32'h00000001);
    wait_until(0, 1'b1);
    spl_peer_model_inst.level(1'b1);
    wait_until(0, 1'b0);
    spl_peer_model_inst.level(1'b0);
    wait_until(0, 1'b1);
    wr(12'h008, 32'h00000004);
    // latch mode keeps running after the level drops away
    wr(12'h000, 32'h00000003);
    wr(12'h008, 32'h00000001);
    wait_until(0, 1'b1);
    spl_peer_model_inst.level(1'b1);
    repeat (20) @(negedge clk);
    chk(routine_active, 1'b1);
    wr(12'h008, 32'h00000002);
    wait_until(0, 1'b0);
    // master/slave: dormant slave, swap, done, restart as master, stop
    wr(12'h014, 32'hffffffff);
    wr(12'h000, 32'h0000000c);
    repeat (3) @(negedge clk);
    chk(bottle_ms_out, 1'b0);
    wr(12'h008, 32'h00000001);
    repeat (20) @(negedge clk);
    chk({routine_active, is_master, bottle_ms_out}, 32'h00000000);
    spl_peer_model_inst.level(1'b0);
    wait_until(1, 1'b1);
    chk(bottle_ms_out, 1'b1);
    rd(12'h014, 32'h00000004);
    wr(12'h008, 32'h00000002);
    wait_until(1, 1'b0);
    repeat (20) @(negedge clk);
    chk({routine_active, bottle_ms_out}, 32'h00000000);
    wr(12'h008, 32'h00000001);
    wait_until(1, 1'b1);
    wr(12'h008, 32'h00000004);
    wait_until(2, 1'b0);
    wr(12'h000, 32'h00000008);
    wait_until(2, 1'b1);
    report_and_stop;
  end
endmodule // spl_pacing_tb
`default_nettype wire
